// file: logic/kpa_pkg.sv
// Constants shared by the keypad parameter access logic.
// Assumes a 100 MHz single clock and an AXI4-Lite register port.
package kpa_pkg;
   // ------------------------------------------------------------
   // Access levels as decoded from the two rear switches
   // ------------------------------------------------------------
   localparam logic [1:0] KPA_LVL_LOCK = 2'h0; // Default position: lockout
   localparam logic [1:0] KPA_LVL_1 = 2'h1;
   localparam logic [1:0] KPA_LVL_2 = 2'h2;
   localparam logic [1:0] KPA_LVL_3 = 2'h3;
   // ------------------------------------------------------------
   // Parameter map
   // ------------------------------------------------------------
   localparam int KPA_IDX_W = 4;
   localparam int KPA_NPARAM = 16;
   localparam logic [3:0] KPA_IDX_MON = 4'h0; // Display selection
   localparam logic [3:0] KPA_IDX_DECEL = 4'h2; // Deceleration ramp time
   localparam logic [3:0] KPA_L1_LAST = 4'h5; // Last level 1 parameter
   localparam logic [3:0] KPA_L2_LAST = 4'h9; // Last level 2 parameter
   localparam logic [3:0] KPA_CFG_FIRST = 4'hA; // Configuration parameters
   localparam logic [7:0] KPA_PAR_RST = 8'h0A;
   localparam logic [7:0] KPA_STEP_RST = 8'h01;
   localparam logic [7:0] KPA_VAL_MAX = 8'hFF;
   // ------------------------------------------------------------
   // Keys
   // ------------------------------------------------------------
   localparam int KPA_KEY_FWD = 0;
   localparam int KPA_KEY_BACK = 1;
   localparam int KPA_KEY_TOG = 2;
   localparam int KPA_KEY_SAVE = 3;
   // ------------------------------------------------------------
   // Register map (byte addresses) and bus answers
   // ------------------------------------------------------------
   localparam int KPA_AW = 8;
   localparam logic [7:0] KPA_REG_STATUS = 8'h00;
   localparam logic [7:0] KPA_REG_STEP = 8'h04;
   localparam logic [7:0] KPA_REG_PSEL = 8'h08;
   localparam logic [7:0] KPA_REG_PDATA = 8'h0C;
   localparam logic [7:0] KPA_REG_MON = 8'h10;
   localparam logic [7:0] KPA_REG_DECEL = 8'h14;
   localparam logic [1:0] KPA_RESP_OK = 2'h0;
   localparam logic [1:0] KPA_RESP_ERR = 2'h2;
   typedef enum logic {KPA_NAME, KPA_VALUE} kpa_view_t;
endpackage

// file: logic/kpa_keypad_access.sv
// Keypad menu logic: level switches, four keys, parameter edit and save.
// Assumes run_cmd, ctrl_ready, motor_running and fault_active come from
// logic on aclk; keys and switches are raw pins and are synchronised here.
//
// Overview of operation
// - Three access levels; two rear switches pick a level or lock out.
// - Default switch position (both off) blocks every modification.
// - Lockout: run command still works, level 2 list and faults viewable, no edits.
// - Level 3 while ready and idle: configuration parameters editable, faults shown, LED lit.
// - Configuration parameters change only when ready; while running view only.
// - Adjustment parameters change any time in setup mode, idle or running.
// - Forward key: next parameter on a name, increment on a value.
// - Backward key: previous parameter on a name, decrement on a value.
// - Toggle key: name shows value; value returns to name, dropping the edit.
// - Save key stores the edit when a value is shown; ignored on a name.
// - Edited deceleration time takes effect at the next stop command.
// - Display choice made while idle is shown at the next start.
// - Monitoring choice made while running is shown after the toggle key.
`timescale 1ns/1ps
module kpa_keypad_access
   import kpa_pkg::*;
#(
   parameter int NPARAM = KPA_NPARAM
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Keypad pins
   input wire logic [3:0] key_pin,
   input wire logic [1:0] level_sw_pin,
   // Controller status
   input wire logic run_cmd,
   input wire logic ctrl_ready,
   input wire logic motor_running,
   input wire logic fault_active,
   // Display and controller outputs
   output logic programming_indicator,
   output logic fault_show,
   output logic disp_value_mode,
   output logic [KPA_IDX_W-1:0] disp_idx,
   output logic [7:0] disp_edit,
   output logic [7:0] mon_sel,
   output logic [7:0] decel_time,
   // AXI4-Lite slave
   input wire logic [KPA_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [KPA_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (NPARAM > (1 << KPA_IDX_W) || NPARAM <= int'(KPA_CFG_FIRST)) begin : g_bad
      $error("NPARAM out of range for the parameter map");
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [3:0] key_s1;
      logic [3:0] key_s2;
      logic [3:0] key_prev;
      logic [1:0] sw_s1;
      logic [1:0] sw_s2;
      logic [1:0] lvl;
      kpa_view_t view;
      logic [KPA_IDX_W-1:0] idx;
      logic [7:0] edit;
      logic [NPARAM-1:0][7:0] par;
      logic [7:0] mon_pend;
      logic [7:0] mon_show;
      logic [7:0] decel;
      logic run_prev;
      logic led;
      logic fault;
      logic [7:0] step;
      logic [KPA_IDX_W-1:0] psel;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } kpa_state_t;

   kpa_state_t s_r;
   kpa_state_t s_nxt;
   logic [3:0] press;
   logic start_p;
   logic stop_p;
   logic [KPA_IDX_W-1:0] lo;
   logic [KPA_IDX_W-1:0] hi;
   logic editable;
   logic wr_go;
   logic rd_go;
   logic [8:0] inc_sum;

   // ------------------------------------------------------------
   // Decode of keys, run edges, visible range, edit permission
   // ------------------------------------------------------------
   // Edge detect reads the second sync stage only
   assign press = s_r.key_s2 & ~s_r.key_prev;
   // Run edges are seen in every level, lockout included
   assign start_p = run_cmd & ~s_r.run_prev;
   assign stop_p = ~run_cmd & s_r.run_prev;
   assign inc_sum = {1'b0, s_r.edit} + {1'b0, s_r.step};
   assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_r.bvalid;
   assign rd_go = s_axi_arvalid & ~s_r.rvalid;

   // Visible list per level; lockout shows the level 2 list
   always_comb begin
      case (s_r.lvl)
         KPA_LVL_1: begin
            lo = '0;
            hi = KPA_L1_LAST;
         end
         KPA_LVL_3: begin
            lo = KPA_CFG_FIRST;
            hi = KPA_IDX_W'(NPARAM - 1);
         end
         default: begin
            lo = '0;
            hi = KPA_L2_LAST;
         end
      endcase
   end

   // Configuration needs level 3 and ready; adjustment any time in setup
   always_comb begin
      if (s_r.lvl == KPA_LVL_LOCK) begin
         editable = 1'b0;
      end else if (s_r.idx >= KPA_CFG_FIRST) begin
         editable = (s_r.lvl == KPA_LVL_3) && ctrl_ready && !motor_running;
      end else begin
         editable = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.key_s1 = key_pin;
      s_nxt.key_s2 = s_r.key_s1;
      s_nxt.key_prev = s_r.key_s2;
      s_nxt.sw_s1 = level_sw_pin;
      s_nxt.sw_s2 = s_r.sw_s1;
      s_nxt.lvl = s_r.sw_s2;
      s_nxt.run_prev = run_cmd;
      s_nxt.fault = fault_active;
      s_nxt.led = (s_r.lvl == KPA_LVL_3) && ctrl_ready && !motor_running;
      // Menu walk; a level change restarts at the top of the new list
      if (s_r.sw_s2 != s_r.lvl) begin
         s_nxt.view = KPA_NAME;
         s_nxt.idx = (s_r.sw_s2 == KPA_LVL_3) ? KPA_CFG_FIRST : '0;
      end else if (s_r.view == KPA_NAME) begin
         if (press[KPA_KEY_TOG]) begin
            s_nxt.view = KPA_VALUE;
            s_nxt.edit = s_r.par[s_r.idx];
         end else if (press[KPA_KEY_FWD]) begin
            s_nxt.idx = (s_r.idx >= hi) ? lo : s_r.idx + 1'b1;
         end else if (press[KPA_KEY_BACK]) begin
            s_nxt.idx = (s_r.idx <= lo) ? hi : s_r.idx - 1'b1;
         end
      end else begin
         if (press[KPA_KEY_SAVE]) begin
            if (editable) begin
               s_nxt.par[s_r.idx] = s_r.edit;
               if (s_r.idx == KPA_IDX_MON) begin
                  s_nxt.mon_pend = s_r.edit;
               end
            end
         end else if (press[KPA_KEY_TOG]) begin
            s_nxt.view = KPA_NAME;
            s_nxt.edit = s_r.par[s_r.idx];
         end else if (press[KPA_KEY_FWD] && editable) begin
            s_nxt.edit = inc_sum[8] ? KPA_VAL_MAX : inc_sum[7:0];
         end else if (press[KPA_KEY_BACK] && editable) begin
            s_nxt.edit = (s_r.edit < s_r.step) ? 8'h00 : s_r.edit - s_r.step;
         end
      end
      // Display choice: idle choice waits for a start, running one for toggle
      if (start_p) begin
         s_nxt.mon_show = s_r.mon_pend;
      end else if (motor_running && press[KPA_KEY_TOG]) begin
         s_nxt.mon_show = s_r.mon_pend;
      end
      // Ramp time latched at the stop edge so a ramp never changes midway
      if (stop_p) begin
         s_nxt.decel = s_r.par[KPA_IDX_DECEL];
      end
      // Register writes; only byte lane 0 carries data
      if (wr_go) begin
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = KPA_RESP_OK;
         case (s_axi_awaddr)
            KPA_REG_STEP: begin
               if (s_axi_wstrb[0]) begin
                  s_nxt.step = s_axi_wdata[7:0];
               end
            end
            KPA_REG_PSEL: begin
               if (s_axi_wstrb[0]) begin
                  s_nxt.psel = s_axi_wdata[KPA_IDX_W-1:0];
               end
            end
            KPA_REG_STATUS, KPA_REG_PDATA, KPA_REG_MON, KPA_REG_DECEL: begin
               s_nxt.bresp = KPA_RESP_OK; // Read-only, write ignored
            end
            default: s_nxt.bresp = KPA_RESP_ERR;
         endcase
      end else if (s_r.bvalid && s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      // Register reads
      if (rd_go) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = KPA_RESP_OK;
         s_nxt.rdata = '0;
         case (s_axi_araddr)
            KPA_REG_STATUS: begin
               s_nxt.rdata[11:0] = {s_r.fault, motor_running, ctrl_ready, s_r.led,
                  s_r.view == KPA_VALUE, editable, s_r.lvl, s_r.idx};
            end
            KPA_REG_STEP: s_nxt.rdata[7:0] = s_r.step;
            KPA_REG_PSEL: s_nxt.rdata[KPA_IDX_W-1:0] = s_r.psel;
            KPA_REG_PDATA: begin
               s_nxt.rdata[7:0] = (int'(s_r.psel) < NPARAM) ? s_r.par[s_r.psel] : 8'h00;
            end
            KPA_REG_MON: s_nxt.rdata[15:0] = {s_r.mon_pend, s_r.mon_show};
            KPA_REG_DECEL: s_nxt.rdata[7:0] = s_r.decel;
            default: s_nxt.rresp = KPA_RESP_ERR;
         endcase
      end else if (s_r.rvalid && s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      // Synchronous reset; lockout state until the switches are read
      if (!aresetn) begin
         s_nxt = '0;
         s_nxt.step = KPA_STEP_RST;
         s_nxt.edit = KPA_PAR_RST;
         s_nxt.decel = KPA_PAR_RST;
         s_nxt.mon_pend = KPA_PAR_RST;
         s_nxt.mon_show = KPA_PAR_RST;
         for (int i = 0; i < NPARAM; i++) begin
            s_nxt.par[i] = KPA_PAR_RST;
         end
      end
   end

   // Single state register
   always_ff @(posedge aclk) begin
      s_r <= s_nxt;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign programming_indicator = s_r.led;
   assign fault_show = s_r.fault;
   assign disp_value_mode = (s_r.view == KPA_VALUE);
   assign disp_idx = s_r.idx;
   assign disp_edit = s_r.edit;
   assign mon_sel = s_r.mon_show;
   assign decel_time = s_r.decel;
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_arready = rd_go;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rresp = s_r.rresp;
   assign s_axi_rdata = s_r.rdata;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_lock_no_save: assert property ((s_r.lvl == KPA_LVL_LOCK) |=> $stable(s_r.par))
      else $error("parameter changed in lockout");
   a_lock_no_edit: assert property ((s_r.lvl == KPA_LVL_LOCK && s_r.view == KPA_VALUE
      && s_r.sw_s2 == s_r.lvl && !press[KPA_KEY_TOG]) |=> $stable(s_r.edit))
      else $error("edit moved in lockout");
   a_led_level3: assert property (##1 (programming_indicator ==
      ($past(s_r.lvl) == KPA_LVL_3 && $past(ctrl_ready) && !$past(motor_running))))
      else $error("programming indicator wrong");
   a_cfg_running: assert property ((motor_running && s_r.idx >= KPA_CFG_FIRST)
      |=> s_r.par[$past(s_r.idx)] == $past(s_r.par[s_r.idx]))
      else $error("configuration changed while running");
   a_adj_save: assert property ((s_r.lvl != KPA_LVL_LOCK && s_r.view == KPA_VALUE
      && s_r.idx < KPA_CFG_FIRST && press[KPA_KEY_SAVE] && s_r.sw_s2 == s_r.lvl)
      |=> s_r.par[$past(s_r.idx)] == $past(s_r.edit))
      else $error("adjustment save lost");
   a_fwd_name: assert property ((s_r.view == KPA_NAME && press == 4'h1
      && s_r.sw_s2 == s_r.lvl && s_r.idx < hi) |=> s_r.idx == $past(s_r.idx) + 1'b1)
      else $error("forward step wrong");
   a_back_name: assert property ((s_r.view == KPA_NAME && press == 4'h2
      && s_r.sw_s2 == s_r.lvl && s_r.idx > lo) |=> s_r.idx == $past(s_r.idx) - 1'b1)
      else $error("backward step wrong");
   a_tog_cancel: assert property ((s_r.view == KPA_VALUE && press == 4'h4
      && s_r.sw_s2 == s_r.lvl) |=> s_r.view == KPA_NAME ##0
      s_r.edit == s_r.par[s_r.idx])
      else $error("toggle did not cancel");
   a_name_save: assert property ((s_r.view == KPA_NAME) |=> $stable(s_r.par))
      else $error("stored value moved without save");
   a_decel_stop: assert property ((!stop_p) |=> $stable(s_r.decel))
      else $error("ramp time changed without stop");
   a_mon_start: assert property (start_p |=> mon_sel == $past(s_r.mon_pend))
      else $error("display choice not taken at start");
   a_mon_toggle: assert property ((motor_running && press[KPA_KEY_TOG])
      |=> mon_sel == $past(s_r.mon_pend))
      else $error("monitoring choice not taken at toggle");
   a_bus_resp: assert property (wr_go |=> s_axi_bvalid)
      else $error("write response missing");

   c_level3_save: cover property (s_r.lvl == KPA_LVL_3 && press[KPA_KEY_SAVE] && editable);
   c_run_adjust: cover property (motor_running && s_r.view == KPA_VALUE && press[KPA_KEY_FWD]);
   c_stop_decel: cover property (stop_p ##1 decel_time != KPA_PAR_RST);
   c_lock_view: cover property (s_r.lvl == KPA_LVL_LOCK && s_r.view == KPA_VALUE);
endmodule

// file: test/kpa_operator.sv
// Keypad operator model: presses the four keys and sets the rear switches.
// Assumes keys and switches are sampled on aclk after synchronisation.
`timescale 1ns/1ps
module kpa_operator
   import kpa_pkg::*;
(
   // Clock
   input wire logic aclk,
   // Keypad pins driven by the operator
   output logic [3:0] key_pin,
   output logic [1:0] level_sw_pin
);
   // ------------------------------------------------------------
   // Idle state: no key held, switches in the shipped position
   // ------------------------------------------------------------
   initial begin
      key_pin = 4'h0;
      level_sw_pin = KPA_LVL_LOCK;
   end

   // Hold long enough to cross the synchroniser; release before the next press
   task automatic press(input int k);
      key_pin[k] <= 1'b1;
      repeat (5) @(posedge aclk);
      key_pin[k] <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask

   // Switch move plus the settling edges of sync, level register and list reset
   task automatic set_level(input logic [1:0] v);
      level_sw_pin <= v;
      repeat (8) @(posedge aclk);
   endtask
endmodule

// file: test/testbench.sv
// Self-checking bench for the keypad menu logic.
// Assumes the operator model drives the keypad and the bench speaks AXI4-Lite.
`timescale 1ns/1ps
module testbench;
   import kpa_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic run_cmd = 1'b0, ctrl_ready = 1'b1, motor_running = 1'b0, fault_active = 1'b0;
   logic [3:0] key_pin;
   logic [1:0] level_sw_pin;
   logic programming_indicator, fault_show, disp_value_mode;
   logic [3:0] disp_idx;
   logic [7:0] disp_edit, mon_sel, decel_time;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int fails = 0;
   int samples_checked = 0;

   // ------------------------------------------------------------
   // Clock, design and operator
   // ------------------------------------------------------------
   always #5 aclk = ~aclk;

   kpa_keypad_access kpa_keypad_access_i (.aclk(aclk), .aresetn(aresetn), .key_pin(key_pin),
      .level_sw_pin(level_sw_pin), .run_cmd(run_cmd), .ctrl_ready(ctrl_ready),
      .motor_running(motor_running), .fault_active(fault_active),
      .programming_indicator(programming_indicator), .fault_show(fault_show),
      .disp_value_mode(disp_value_mode), .disp_idx(disp_idx), .disp_edit(disp_edit),
      .mon_sel(mon_sel), .decel_time(decel_time), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   kpa_operator kpa_operator_i (.aclk(aclk), .key_pin(key_pin), .level_sw_pin(level_sw_pin));

   // ------------------------------------------------------------
   // Checks and bus tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Both channels offered together; each released as soon as it is taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit done;
      done = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int i = 0; i < 100 && !done; i++) begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            bready <= 1'b0;
            done = 1;
         end
      end
      if (!done) chk("write timeout", 1, 0);
      chk("bresp", KPA_RESP_OK, bresp);
      // Idle edge so a following call never re-raises a just-lowered strobe
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
      bit done;
      done = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int i = 0; i < 100 && !done; i++) begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            rready <= 1'b0;
            done = 1;
            chk("rresp", er, rresp);
            chk("rdata", ed, rdata);
         end
      end
      if (!done) chk("read timeout", 1, 0);
      @(posedge aclk);
   endtask

   // Stored value of one parameter through the select and data registers
   task automatic par(input logic [3:0] idx, input logic [7:0] exp);
      wr(KPA_REG_PSEL, {28'h000_0000, idx});
      rd(KPA_REG_PDATA, KPA_RESP_OK, {24'h00_0000, exp});
   endtask

   task automatic key(input int k);
      kpa_operator_i.press(k);
   endtask

   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Watchdog: the whole sequence needs well under 2000 cycles
   // ------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge aclk);
      fails++;
      close_out;
   end

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      // Reset state and an unmapped address
      chk("mon_sel", KPA_PAR_RST, mon_sel);
      chk("decel_time", KPA_PAR_RST, decel_time);
      rd(KPA_REG_STEP, KPA_RESP_OK, 32'h0000_0001);
      rd(8'h18, KPA_RESP_ERR, 32'h0000_0000);
      $display("Test reset done");
      // Lockout: level 2 list browsable, nothing editable
      key(KPA_KEY_BACK);
      chk("disp_idx", 4'h9, disp_idx);
      key(KPA_KEY_TOG);
      chk("disp_value_mode", 1, disp_value_mode);
      key(KPA_KEY_FWD);
      chk("disp_edit", KPA_PAR_RST, disp_edit);
      key(KPA_KEY_SAVE);
      rd(KPA_REG_STATUS, KPA_RESP_OK, 32'h0000_0289);
      par(4'h9, KPA_PAR_RST);
      key(KPA_KEY_TOG);
      $display("Test lockout done");
      // Level 1: list wrap, edit, save and deferred ramp time
      kpa_operator_i.set_level(KPA_LVL_1);
      chk("disp_idx", 4'h0, disp_idx);
      key(KPA_KEY_BACK);
      chk("disp_idx", KPA_L1_LAST, disp_idx);
      key(KPA_KEY_FWD);
      key(KPA_KEY_FWD);
      key(KPA_KEY_FWD);
      chk("disp_idx", KPA_IDX_DECEL, disp_idx);
      wr(KPA_REG_STEP, 32'h0000_0003);
      key(KPA_KEY_TOG);
      key(KPA_KEY_FWD);
      chk("disp_edit", 8'h0D, disp_edit);
      key(KPA_KEY_BACK);
      chk("disp_edit", 8'h0A, disp_edit);
      key(KPA_KEY_FWD);
      key(KPA_KEY_FWD);
      par(KPA_IDX_DECEL, KPA_PAR_RST);
      key(KPA_KEY_SAVE);
      par(KPA_IDX_DECEL, 8'h10);
      chk("decel_time", KPA_PAR_RST, decel_time);
      key(KPA_KEY_FWD);
      key(KPA_KEY_TOG);
      chk("disp_value_mode", 0, disp_value_mode);
      key(KPA_KEY_TOG);
      chk("disp_edit", 8'h10, disp_edit);
      key(KPA_KEY_TOG);
      key(KPA_KEY_SAVE);
      chk("disp_value_mode", 0, disp_value_mode);
      run_cmd <= 1'b1;
      repeat (3) @(posedge aclk);
      run_cmd <= 1'b0;
      repeat (3) @(posedge aclk);
      chk("decel_time", 8'h10, decel_time);
      $display("Test level one done");
      // Display selection while idle, then monitoring choice while running
      key(KPA_KEY_BACK);
      key(KPA_KEY_BACK);
      key(KPA_KEY_TOG);
      key(KPA_KEY_FWD);
      key(KPA_KEY_SAVE);
      chk("mon_sel", KPA_PAR_RST, mon_sel);
      rd(KPA_REG_MON, KPA_RESP_OK, 32'h0000_0D0A);
      run_cmd <= 1'b1;
      motor_running <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("mon_sel", 8'h0D, mon_sel);
      key(KPA_KEY_FWD);
      key(KPA_KEY_SAVE);
      par(KPA_IDX_MON, 8'h10);
      chk("mon_sel", 8'h0D, mon_sel);
      key(KPA_KEY_TOG);
      chk("mon_sel", 8'h10, mon_sel);
      run_cmd <= 1'b0;
      motor_running <= 1'b0;
      $display("Test display done");
      // Level 3: configuration edits only while ready and idle
      kpa_operator_i.set_level(KPA_LVL_3);
      chk("disp_idx", KPA_CFG_FIRST, disp_idx);
      chk("programming_indicator", 1, programming_indicator);
      key(KPA_KEY_TOG);
      key(KPA_KEY_FWD);
      chk("disp_edit", 8'h0D, disp_edit);
      key(KPA_KEY_SAVE);
      par(KPA_CFG_FIRST, 8'h0D);
      key(KPA_KEY_FWD);
      motor_running <= 1'b1;
      fault_active <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("programming_indicator", 0, programming_indicator);
      chk("fault_show", 1, fault_show);
      key(KPA_KEY_FWD);
      chk("disp_edit", 8'h10, disp_edit);
      rd(KPA_REG_STATUS, KPA_RESP_OK, 32'h0000_0EBA);
      key(KPA_KEY_SAVE);
      par(KPA_CFG_FIRST, 8'h0D);
      $display("Test level three done");
      close_out;
   end
endmodule
